// ### inc/fer_pkg.sv
// package of constants and carrier types for the fault event recorder
package fer_pkg;
  localparam int SAMP_W       = 16;        // sample width
  localparam int NUM_CH       = 4;         // analog channels
  localparam int STAT_W       = 16;        // element/output/input state bits
  localparam int SET_W        = 32;        // settings snapshot width
  localparam int ROWS         = 44;        // rows per long record
  localparam int TRIG_ROW     = 16;        // trigger row index (1-based)
  localparam int NUM_REC      = 12;        // records retained
  localparam int REARM_CYC    = 4;         // power cycles of dropout to rearm
  localparam int QPC          = 4;         // quarter steps per power cycle
  localparam int REARM_Q      = REARM_CYC * QPC; // dropout in quarter steps
  localparam int NUM_SRC      = 4;         // trigger sources
  localparam logic [1:0] SRC_PROG = 2'h0;  // programmable capture trigger
  localparam logic [1:0] SRC_MAN  = 2'h1;  // manual capture command
  localparam logic [1:0] SRC_EXT  = 2'h2;  // external capture input
  localparam logic [1:0] SRC_TRIP = 2'h3;  // trip output
  localparam int ROW_W        = 5'd0 + 6;  // row index width
  localparam int REC_W        = 4;         // record index width

  typedef logic signed [SAMP_W-1:0] fer_samp_t;

  // one quarter-cycle row: phasor pair per channel plus states
  typedef struct packed {
    logic [NUM_CH-1:0][SAMP_W-1:0] re;     // present filter output
    logic [NUM_CH-1:0][SAMP_W-1:0] im;     // filter output a quarter earlier
    logic [STAT_W-1:0]             stat;   // 1 = asserted/closed/energized
  } fer_row_s;

  // summary fields of one record
  typedef struct packed {
    logic [1:0]                    evType; // triggering source
    logic [31:0]                   stamp;  // date and time
    logic [15:0]                   locat;  // fault location
    logic [3:0]                    shot;   // reclose shot number
    logic [7:0]                    targ;   // fault-type targets
    logic [NUM_CH-1:0][SAMP_W-1:0] curr;   // phase a,b,c and residual
    logic [SAMP_W-1:0]             negSeq; // 3 x negative-sequence
    logic [SET_W-1:0]              sets;   // settings in force
  } fer_sum_s;

  typedef enum logic [1:0] {
    FER_IDLE = 2'b00,  // waiting for a trigger
    FER_POST = 2'b01,  // filling rows after the trigger row
    FER_SEND = 2'b10   // pushing the summary out
  } fer_state_e;
endpackage

// ### hw/fer_buf2.sv
// two-entry valid/ready buffer in the summary output path
`timescale 1ns/10ps
module fer_buf2 #(
  parameter type T = logic [7:0]
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic inValid,
  output logic      inReady,
  input  wire T     inData,
  output logic      outValid,
  input  wire logic outReady,
  output T          outData
);
  typedef struct packed {
    logic [1:0]  cnt;   // entries held
    T            e0;    // head entry
    T            e1;    // second entry
  } fer_buf_s;
  fer_buf_s s_q, s_d;
  logic push, pop;

  // next state of the buffer
  always_comb begin
    s_d  = s_q;
    push = inValid && (s_q.cnt != 2'h2);
    pop  = outReady && (s_q.cnt != 2'h0);
    if (pop) begin
      s_d.e0 = s_q.e1;
    end
    if (push) begin
      if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop)) begin
        s_d.e0 = inData;
      end else begin
        s_d.e1 = inData;
      end
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign inReady  = (s_q.cnt != 2'h2);
  assign outValid = (s_q.cnt != 2'h0);
  assign outData  = s_q.e0;
endmodule

// ### hw/fer_recorder.sv
// fault event recorder: filter, phasors, triggering, record store, summary push
//
// What this block does
// - any of four sources starts a record
// - late trip after record end records again
// - triggering source rearms after four-cycle dropout
// - trigger placed at row sixteen
// - 44 rows of data and states
// - settings snapshot stored with each record
// - twelve records kept, readable on request
// - summary pushed to auto ports not timed out
// - long record sent only on request
// - summary holds time, type, currents
// - clear store on power loss, settings, copy
// - four evenly spaced samples per cycle
// - double differentiator rejects dc and ramp
// - new output per quarter from four samples
// - present output real, previous imaginary
// - state bit one means asserted
`timescale 1ns/10ps
module fer_recorder
  import fer_pkg::*;
#(
  parameter int PORTS = 2     // serial ports
) (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic                                    sampleTick,
  input  wire logic [fer_pkg::NUM_CH-1:0][fer_pkg::SAMP_W-1:0] sampleIn,
  input  wire logic [fer_pkg::STAT_W-1:0]              stateIn,
  input  wire logic [fer_pkg::SET_W-1:0]               settingsIn,
  input  wire logic [31:0]                             stampIn,
  input  wire logic [15:0]                             locatIn,
  input  wire logic [3:0]                              shotIn,
  input  wire logic [7:0]                              targIn,
  input  wire logic                                    faultIn,
  input  wire logic                                    programmableCaptureTrigger,
  input  wire logic                                    manualCapture,
  input  wire logic                                    externalCaptureInput,
  input  wire logic                                    tripOut,
  input  wire logic                                    clearStore,
  input  wire logic [PORTS-1:0]                        portAuto,
  input  wire logic [PORTS-1:0]                        portTimedOut,
  input  wire logic                                    readReq,
  input  wire logic [fer_pkg::REC_W-1:0]               readRec,
  input  wire logic [fer_pkg::ROW_W-1:0]               readRow,
  output logic                                         readValid,
  output fer_pkg::fer_row_s                            readRowData,
  output fer_pkg::fer_sum_s                            readSum,
  output logic                                         sumValid,
  input  wire logic                                    sumReady,
  output fer_pkg::fer_sum_s                            sumData,
  output logic [PORTS-1:0]                             sumPorts,
  output logic [fer_pkg::REC_W-1:0]                    recCount
);
  import fer_pkg::*;

  localparam logic [ROW_W-1:0] ROWS_M1  = ROW_W'(ROWS - 1);
  localparam logic [ROW_W-1:0] POST_N   = ROW_W'(ROWS - TRIG_ROW);
  localparam logic [ROW_W-1:0] PRE_N    = ROW_W'(TRIG_ROW - 1);
  localparam logic [4:0]       REARM_N  = 5'(REARM_Q);
  localparam logic [ROW_W-1:0] MID_ROW  = ROW_W'(TRIG_ROW + (ROWS - TRIG_ROW) / 2);
  localparam int               NW       = SAMP_W + 4;   // headroom for sequence sums
  localparam logic signed [15:0] SIN60  = 16'sh6eda;    // sine of sixty degrees, q15

  typedef struct packed {
    logic [NUM_CH-1:0][SAMP_W-1:0] h0, h1, h2;      // last three samples per channel (h0 newest)
    logic [NUM_CH-1:0][SAMP_W-1:0] fPrev;           // filter output one quarter ago
    fer_row_s                 row;                  // latest formed row
    logic                     rowNew;               // row formed this cycle
    logic [ROW_W-1:0]         wp;                   // circular write pointer
    logic [ROW_W-1:0]         trigPtr;              // slot of trigger row
    logic [ROW_W-1:0]         postCnt;              // rows still to collect
    fer_state_e               st;                   // record sequencer
    logic [NUM_SRC-1:0]       srcPrev;              // sources one cycle ago
    logic [NUM_SRC-1:0]       armed;                // source may trigger
    logic [NUM_SRC-1:0][4:0]  drop;                 // dropout count in quarters
    logic [1:0]               evType;               // source of the record in work
    logic                     pendTrip;             // trip during a record in work
    logic                     stored;               // record copied, summary not yet taken
    fer_sum_s                 sum;                  // summary in work
    logic [REC_W-1:0]         count;                // records held
    logic [REC_W-1:0]         head;                 // slot of newest record
    logic                     rdValid;              // read answer valid
    fer_row_s                 rdRow;                // read row answer
    fer_sum_s                 rdSum;                // read summary answer
  } fer_core_s;

  fer_core_s c_q, c_d;
  fer_row_s  ring_q [ROWS];                          // circular pre/post trigger rows
  fer_row_s  store_q [NUM_REC][ROWS];                // long records, trigger at row 16
  fer_sum_s  sums_q [NUM_REC];                       // summaries
  logic      bufReady;                               // output buffer has room
  logic      pushSum;                                // summary offered to buffer
  logic      commit;                                 // record copied into store
  logic [REC_W-1:0] newSlot;                         // slot taken by new record
  logic [NUM_SRC-1:0] srcNow;                        // current source levels
  logic [NUM_SRC-1:0] rise;                          // rising source edges
  logic               fire;                          // any armed rising edge
  logic [1:0]         fireSrc;                       // source that fired
  logic [NUM_CH-1:0][SAMP_W-1:0] fNow;               // new filter output
  logic [NUM_CH-1:0][SAMP_W-1:0] selRe, selIm;       // row feeding the sequence estimate
  logic signed [NW-1:0]          aRe, aIm, bRe, bIm, cRe, cIm; // phase phasors, sign extended
  logic signed [NW+15:0]         rotRe, rotIm;       // cross terms scaled by sin 60
  logic signed [NW-1:0]          nsRe, nsIm;         // 3 x negative-sequence phasor
  logic [NW-1:0]                 absRe, absIm;       // magnitudes of its parts
  logic [NW-1:0]                 absMax, absMin;     // larger and smaller part
  logic [NW:0]                   magEst;             // larger plus half the smaller
  logic [SAMP_W-1:0]             negMag;             // saturated estimate

  // source levels in the order of their codes
  assign srcNow = {tripOut, externalCaptureInput, manualCapture, programmableCaptureTrigger};
  assign newSlot = (c_q.head == REC_W'(NUM_REC - 1)) ? '0 : c_q.head + 4'h1;

  // double differentiator on four samples: x0 - x1 - x2 + x3 cancels dc and ramp
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      fNow[k] = SAMP_W'(sampleIn[k] - c_q.h0[k] - c_q.h1[k] + c_q.h2[k]);
    end
  end

  // 3 x negative-sequence from phases a, b and c: ia + a^2 ib + a ic
  // the magnitude uses max + min/2, an estimate that needs no root
  always_comb begin
    // trigger row while idle, the newest phasor pair while filling post rows
    selRe  = (c_q.st == FER_IDLE) ? c_q.row.re : fNow;
    selIm  = (c_q.st == FER_IDLE) ? c_q.row.im : c_q.fPrev;
    aRe    = NW'(signed'(selRe[0]));
    aIm    = NW'(signed'(selIm[0]));
    bRe    = NW'(signed'(selRe[1]));
    bIm    = NW'(signed'(selIm[1]));
    cRe    = NW'(signed'(selRe[2]));
    cIm    = NW'(signed'(selIm[2]));
    // cross terms of the two 120 degree rotations
    rotRe  = (bIm - cIm) * SIN60;
    rotIm  = (cRe - bRe) * SIN60;
    nsRe   = aRe - ((bRe + cRe) >>> 1) + NW'(rotRe >>> 15);
    nsIm   = aIm - ((bIm + cIm) >>> 1) + NW'(rotIm >>> 15);
    // absolute values, then larger plus half the smaller
    absRe  = nsRe[NW-1] ? unsigned'(-nsRe) : unsigned'(nsRe);
    absIm  = nsIm[NW-1] ? unsigned'(-nsIm) : unsigned'(nsIm);
    absMax = (absRe > absIm) ? absRe : absIm;
    absMin = (absRe > absIm) ? absIm : absRe;
    magEst = {1'b0, absMax} + {2'b00, absMin[NW-1:1]};
    // saturate to the summary field width
    negMag = (|magEst[NW:SAMP_W]) ? '1 : magEst[SAMP_W-1:0];
  end

  // source edges and priority pick
  always_comb begin
    // an armed source rising this cycle
    rise    = srcNow & ~c_q.srcPrev & c_q.armed;
    fire    = |rise;
    fireSrc = SRC_PROG;
    if (rise[SRC_TRIP]) begin
      fireSrc = SRC_TRIP;
    end else if (rise[SRC_EXT]) begin
      fireSrc = SRC_EXT;
    end else if (rise[SRC_MAN]) begin
      fireSrc = SRC_MAN;
    end
  end

  // next state of the core
  always_comb begin
    c_d         = c_q;
    // one-cycle strobes fall unless set below
    c_d.rowNew  = 1'b0;
    c_d.rdValid = 1'b0;
    c_d.srcPrev = srcNow;
    pushSum     = 1'b0;
    commit      = 1'b0;
    // sample step: shift history, form phasor row
    if (sampleTick) begin
      c_d.h0 = sampleIn;
      c_d.h1 = c_q.h0;
      c_d.h2 = c_q.h1;
      // phasor pair: new output real, previous output imaginary
      c_d.fPrev    = fNow;
      c_d.row.re   = fNow;
      c_d.row.im   = c_q.fPrev;
      c_d.row.stat = stateIn;
      c_d.rowNew   = 1'b1;
      c_d.wp       = (c_q.wp == ROWS_M1) ? '0 : c_q.wp + 6'h1;
      // dropout timing per source in quarter steps
      for (int s = 0; s < NUM_SRC; s++) begin
        if (!c_q.armed[s]) begin
          if (srcNow[s]) begin
            c_d.drop[s] = '0;
          end else if (c_q.drop[s] == REARM_N - 5'h1) begin
            c_d.armed[s] = 1'b1;
          end else begin
            c_d.drop[s] = c_q.drop[s] + 5'h1;
          end
        end
      end
    end
    // a disarmed source seen high between ticks restarts its dropout
    for (int s = 0; s < NUM_SRC; s++) begin
      if (!c_q.armed[s] && srcNow[s] && !sampleTick) begin
        c_d.drop[s] = '0;
      end
    end
    // record sequencer
    case (c_q.st)
      FER_IDLE: begin
        // latch the trigger instant and the fields known now
        if (fire || c_q.pendTrip) begin
          c_d.evType         = fire ? fireSrc : SRC_TRIP;
          c_d.pendTrip       = 1'b0;
          c_d.trigPtr        = c_q.wp;
          c_d.postCnt        = POST_N;
          c_d.sum.evType     = fire ? fireSrc : SRC_TRIP;
          c_d.sum.stamp      = stampIn;
          c_d.sum.shot       = shotIn;
          c_d.sum.sets       = settingsIn;
          c_d.sum.curr       = c_q.row.re;
          c_d.sum.negSeq     = negMag;
          c_d.st             = FER_POST;
        end
      end
      FER_POST: begin
        // a trip inside the window is queued and disarmed like any trigger
        if (rise[SRC_TRIP]) begin
          c_d.pendTrip        = 1'b1;
          c_d.armed[SRC_TRIP] = 1'b0;
          c_d.drop[SRC_TRIP]  = '0;
        end
        if (sampleTick) begin
          c_d.postCnt = c_q.postCnt - 6'h1;
          // currents near mid-fault when a fault is present
          if (faultIn && (POST_N - c_q.postCnt) == MID_ROW - ROW_W'(TRIG_ROW)) begin
            c_d.sum.curr   = fNow;
            c_d.sum.negSeq = negMag;
          end
          if (c_q.postCnt == 6'h1) begin
            c_d.sum.locat = locatIn;
            c_d.sum.targ  = targIn;
            c_d.st        = FER_SEND;
          end
        end
      end
      FER_SEND: begin
        // store at once, before a later tick overwrites the oldest pre row
        if (!c_q.stored) begin
          commit     = 1'b1;
          c_d.stored = 1'b1;
          c_d.head   = newSlot;
          c_d.count  = (c_q.count == REC_W'(NUM_REC)) ? c_q.count : c_q.count + 4'h1;
        end
        if (bufReady) begin
          pushSum    = 1'b1;
          c_d.stored = 1'b0;
          c_d.st     = FER_IDLE;
        end
      end
      default: c_d.st = FER_IDLE;
    endcase
    // any triggering source that started a record disarms until dropout
    if (c_q.st == FER_IDLE && (fire || c_q.pendTrip)) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (rise[s]) begin
          c_d.armed[s] = 1'b0;
          c_d.drop[s]  = '0;
        end
      end
    end
    // read path: index 1 is the newest record
    if (readReq && readRec != '0 && readRec <= c_q.count) begin
      c_d.rdValid = 1'b1;
      c_d.rdRow   = store_q[(c_q.head >= readRec - 4'h1) ? c_q.head - (readRec - 4'h1)
                             : c_q.head + REC_W'(NUM_REC) - (readRec - 4'h1)][readRow];
      c_d.rdSum   = sums_q[(c_q.head >= readRec - 4'h1) ? c_q.head - (readRec - 4'h1)
                             : c_q.head + REC_W'(NUM_REC) - (readRec - 4'h1)];
    end
    // store and history list empty together
    if (clearStore) begin
      c_d.count = '0;
    end
  end

  // core state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_q       <= '0;
      c_q.armed <= '1;
      c_q.st    <= FER_IDLE;
    end else begin
      c_q <= c_d;
    end
  end

  // circular row buffer and record copy
  always_ff @(posedge clk) begin
    if (c_q.rowNew) begin
      ring_q[c_q.wp] <= c_q.row;
    end
    // the row of the last post tick is written this cycle, so it is taken from the core
    if (commit) begin
      for (int r = 0; r < ROWS; r++) begin
        // slot of row r relative to trigger row at index 15
        if (c_q.rowNew && ROW_W'((32'(c_q.trigPtr) + ROWS + r - 32'(PRE_N)) % ROWS) == c_q.wp) begin
          store_q[newSlot][r] <= c_q.row;
        end else begin
          store_q[newSlot][r] <= ring_q[(32'(c_q.trigPtr) + ROWS + r - 32'(PRE_N)) % ROWS];
        end
      end
      sums_q[newSlot] <= c_q.sum;
    end
  end

  // summary output buffer, held until a port takes it
  fer_buf2 #(
    .T(fer_sum_s)
  ) u_sumBuf (
    .clk      (clk),
    .rst      (rst),
    .inValid  (pushSum),
    .inReady  (bufReady),
    .inData   (c_q.sum),
    .outValid (sumValid),
    .outReady (sumReady),
    .outData  (sumData)
  );

  // ports eligible for unprompted summary; timeout zero keeps portTimedOut low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sumPorts <= '0;
    end else begin
      sumPorts <= portAuto & ~portTimedOut;
    end
  end

  // read answer and count come straight from the core register
  assign readValid   = c_q.rdValid;
  assign readRowData = c_q.rdRow;
  assign readSum     = c_q.rdSum;
  assign recCount    = c_q.count;
endmodule

// ### sim/fer_sink.sv
// serial port sink taking summaries, promptly or with stalls
`timescale 1ns/10ps
module fer_sink (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic sumValid,
  output logic      sumReady
);
  // ready every cycle, or now and then while a word waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sumReady <= 1'b0;
    else sumReady <= !slow || (sumValid && ($urandom % 4 == 0));
  end
endmodule

// ### sim/fer_recorder_asserts.sv
// port checks on the fault event recorder
`timescale 1ns/10ps
module fer_recorder_asserts
  import fer_pkg::*;
#(
  parameter int PORTS = 2
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      clearStore,
  input wire logic [PORTS-1:0]          portAuto,
  input wire logic [PORTS-1:0]          portTimedOut,
  input wire logic                      readReq,
  input wire logic [fer_pkg::REC_W-1:0] readRec,
  input wire logic                      readValid,
  input wire logic                      sumValid,
  input wire logic                      sumReady,
  input wire fer_pkg::fer_sum_s         sumData,
  input wire logic [PORTS-1:0]          sumPorts,
  input wire logic [fer_pkg::REC_W-1:0] recCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a read of a stored record
  sequence read_ok;
    readReq && readRec != 0 && readRec <= recCount;
  endsequence
  // the store just took a record
  sequence rec_done;
    recCount != $past(recCount) && recCount != 0;
  endsequence
  count_max_a: assert property (recCount <= NUM_REC) else $error("record count above limit");
  count_step_a: assert property (recCount != $past(recCount) |->
    recCount == $past(recCount) + 4'h1 || recCount == 4'h0) else $error("record count jumped");
  clear_empty_a: assert property (clearStore |=> recCount == 4'h0) else $error("store not emptied");
  auto_ports_a: assert property (!$past(rst) |->
    sumPorts == ($past(portAuto) & ~$past(portTimedOut))) else $error("wrong port set");
  read_answer_a: assert property (read_ok |=> readValid) else $error("read not answered");
  read_only_a: assert property (readValid |-> $past(readReq) && $past(readRec) != 0 &&
    $past(readRec) <= $past(recCount)) else $error("unrequested read data");
  push_after_a: assert property (rec_done |-> ##[0:2] sumValid) else $error("summary not pushed");
  sum_hold_a: assert property (sumValid && !sumReady |=> sumValid && $stable(sumData))
    else $error("summary dropped in stall");
endmodule

bind fer_recorder fer_recorder_asserts #(.PORTS(PORTS)) i_fer_recorder_asserts (.clk(clk), .rst(rst),
  .clearStore(clearStore), .portAuto(portAuto), .portTimedOut(portTimedOut), .readReq(readReq),
  .readRec(readRec), .readValid(readValid), .sumValid(sumValid), .sumReady(sumReady),
  .sumData(sumData), .sumPorts(sumPorts), .recCount(recCount));

// ### sim/test_fer_recorder.sv
// self-checking bench for the fault event recorder
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_fer_recorder;
  import fer_pkg::*;
  localparam int PORTS = 2;
  logic clk, rst, tick, clr, rdReq, slow, fault, sumValid, sumReady, readValid;
  logic [NUM_CH-1:0][SAMP_W-1:0] samp, slope; // ramp samples
  logic [STAT_W-1:0] stat;
  logic [SET_W-1:0] sets;
  logic [31:0] stamp;
  logic [15:0] locat;
  logic [3:0] shot, src;
  logic [7:0] targ;
  logic [PORTS-1:0] autoP, tmo, sumPorts;
  logic [REC_W-1:0] rdRec, recCount;
  logic [ROW_W-1:0] rdRow;
  logic [1:0] tcnt;
  fer_row_s rowData;
  fer_sum_s rdSum, sumData;
  int err_count, cmp_count, n;
  logic [175:0] sq[$]; // expected summaries with port set
  logic [207:0] rq[$]; // expected read answers
  logic [207:0] hist[0:31];
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // quarter-cycle tick every four clocks, ramp advances on it
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    if (tcnt == 2'h3) for (int c = 0; c < NUM_CH; c++) samp[c] <= samp[c] + slope[c];
  end
  fer_recorder #(.PORTS(PORTS)) i_fer_recorder (.clk(clk), .rst(rst), .sampleTick(tick), .sampleIn(samp),
    .stateIn(stat), .settingsIn(sets), .stampIn(stamp), .locatIn(locat), .shotIn(shot), .targIn(targ),
    .faultIn(fault), .programmableCaptureTrigger(src[0]), .manualCapture(src[1]),
    .externalCaptureInput(src[2]), .tripOut(src[3]), .clearStore(clr), .portAuto(autoP),
    .portTimedOut(tmo), .readReq(rdReq), .readRec(rdRec), .readRow(rdRow), .readValid(readValid),
    .readRowData(rowData), .readSum(rdSum), .sumValid(sumValid), .sumReady(sumReady),
    .sumData(sumData), .sumPorts(sumPorts), .recCount(recCount));
  fer_sink i_fer_sink (.clk(clk), .rst(rst), .slow(slow), .sumValid(sumValid), .sumReady(sumReady));
  // watcher: oldest note against each result
  always @(posedge clk) begin
    if (sumValid && sumReady) begin
      if (sq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({sumData, sumPorts}, sq.pop_front())
    end
    if (readValid) begin
      if (rq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({rowData, rdSum.sets, rdSum.stamp}, rq.pop_front())
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic ticks(input int m);
    repeat (m * 4) @(posedge clk);
  endtask
  // bounded wait until all notes are used up
  task automatic waitq();
    int k;
    k = 0;
    while ((sq.size() != 0 || rq.size() != 0) && k < 800) begin
      @(posedge clk);
      k++;
    end
    if (k >= 800) begin
      err_count++;
      end_sim();
    end
  endtask
  function automatic logic [REC_W-1:0] cap(input int k);
    return REC_W'((k > NUM_REC) ? NUM_REC : k);
  endfunction
  // new levels, settle pre rows and rearm, then raise a source
  task automatic trig(input int s, input bit keep);
    stat <= STAT_W'($urandom);
    sets <= SET_W'($urandom);
    stamp <= $urandom;
    {locat, shot, targ, fault} <= 29'($urandom);
    autoP <= PORTS'($urandom) | 2'h1;
    tmo <= PORTS'($urandom) & 2'h2;
    slow <= 1'($urandom);
    ticks(20);
    sq.push_back({s[1:0], stamp, locat, shot, targ, 80'h0, sets, autoP & ~tmo});
    hist[n] = {128'h0, stat, sets, stamp};
    n++;
    src[s] <= 1'b1;
    waitq();
    if (!keep) src[s] <= 1'b0;
  endtask
  task automatic rd(input int r);
    if (r >= 1 && r <= cap(n)) rq.push_back(hist[n - r]);
    rdRec <= r[3:0];
    rdRow <= ROW_W'($urandom % ROWS);
    rdReq <= 1'b1;
    @(posedge clk);
    rdReq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    {rst, tcnt, tick, clr, rdReq, slow, fault, src, autoP, tmo, rdRec, rdRow} = '0;
    {samp, stat, sets, stamp, locat, shot, targ, err_count, cmp_count, n} = '0;
    rst = 1'b1;
    n = $urandom(32'h525b4d0e);
    n = 0;
    slope = {$urandom, $urandom};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    ticks(30);
    trig(2, 0);
    ticks(8);
    src[2] <= 1'b1;
    ticks(40);
    src[2] <= 1'b0;
    `CHK(recCount, 4'h1)
    trig(0, 1);
    trig(3, 0);
    src[0] <= 1'b0;
    `CHK(recCount, 4'h3)
    $display("test rearm and late trip done");
    for (int i = 0; i < 12; i++) trig(i % 4, 0);
    `CHK(recCount, 4'hc)
    for (int r = 0; r < 14; r++) rd(r);
    waitq();
    $display("test store and reads done");
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    `CHK(recCount, 4'h0)
    n = 0;
    rd(1);
    trig(1, 0);
    rd(1);
    waitq();
    `CHK(recCount, 4'h1)
    $display("test clear done");
    end_sim();
  end
endmodule
